// File: pboa_params.svh
// Constants for the breakpoint output action block.
// Assumes a 32-bit AHB-Lite slave decoding the low eight address bits.
`ifndef PBOA_PARAMS_SVH
`define PBOA_PARAMS_SVH
`define PBOA_AXES      4
`define PBOA_OFS_ON    5'h00
`define PBOA_OFS_OFF   5'h04
`define PBOA_OFS_BKPT  5'h08
`define PBOA_OFS_CTRL  5'h0C
`define PBOA_OFS_PRE   5'h10
`define PBOA_OFS_SFT   5'h14
`define PBOA_OFS_POS   5'h18
`define PBOA_OFS_GPO   8'h80
`define PBOA_RST_MASK  32'h00000000
`define PBOA_RST_BKPT  32'h00000000
`define PBOA_RST_POS   32'h00000000
`define PBOA_RST_GPO   32'h00000000
`define PBOA_RST_EN    1'b0
`endif

// File: pboa_pkg.sv
// Types shared by the breakpoint output action block.
// Assumes the constants header is compiled alongside.
package pboa_pkg;
  typedef struct packed {
    logic [31:0] on_mask;
    logic [31:0] off_mask;
    logic [31:0] bkpt;
    logic        en;
  } pboa_axis_cfg_t;
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } pboa_dphase_t;
endpackage

// File: pboa_core.sv
// Per-axis position counters with breakpoint-driven output masks.
// Assumes one AHB-Lite master, hready tied to hreadyout, one clock.
// Function
// - Axis breakpoint drives every output in its off mask high.
// - Axis breakpoint drives every output in its on mask low, unless an off mask that fires in the same cycle also has that bit.
// - Outputs with clear mask bits keep their level on breakpoint.
// - Masks are 32 bits, bit k controls general output k.
// - Each axis has its own mask pair, applied only on its breakpoint.
// - No mask action unless that axis breakpoint is enabled.
// - Masks persist across breakpoint events until rewritten.
// - Preset loads the axis counter with a signed 32-bit value.
// - Preset clears the axis breakpoint enable.
// - Shift adds a signed offset without losing encoder counts.
// - Shift clears the axis breakpoint enable.
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "pboa_params.svh"
module pboa_core
  import pboa_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic [`PBOA_AXES-1:0] enc_up,
  input  wire logic [`PBOA_AXES-1:0] enc_dn,
  output logic [31:0]                general_output,
  output logic [`PBOA_AXES-1:0]      bkpt_event
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  pboa_dphase_t           dph_q, dph_d;
  logic [31:0]            hrdata_q, hrdata_d;
  pboa_axis_cfg_t         cfg_q [`PBOA_AXES];
  pboa_axis_cfg_t         cfg_d [`PBOA_AXES];
  logic [31:0]            pos_q [`PBOA_AXES];
  logic [31:0]            pos_d [`PBOA_AXES];
  logic [31:0]            step  [`PBOA_AXES];
  logic [31:0]            gpo_q, gpo_d;
  logic [`PBOA_AXES-1:0]  fire_q, fire;
  logic [`PBOA_AXES-1:0]  pre_wr, sft_wr, mask_wr;
  logic [31:0]            on_sum, off_sum;
  logic                   wr, gpo_wr;
  logic [4:0]             sub;
  logic [1:0]             ax;

  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign hrdata         = hrdata_q;
  assign general_output = gpo_q;
  assign bkpt_event     = fire_q;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    dph_d.valid = hsel && htrans[1] && hready;
    dph_d.write = hwrite;
    dph_d.addr  = haddr[7:0];
    wr     = dph_q.valid && dph_q.write;
    ax     = dph_q.addr[6:5];
    sub    = dph_q.addr[4:0];
    gpo_wr = wr && (dph_q.addr == `PBOA_OFS_GPO);
    hrdata_d = 32'h00000000;
    if (dph_d.valid && !hwrite)
    begin
      if (haddr[7:0] == `PBOA_OFS_GPO)
        hrdata_d = gpo_q;
      else if (!haddr[7])
      begin
        case (haddr[4:0])
          `PBOA_OFS_ON:   hrdata_d = cfg_q[haddr[6:5]].on_mask;
          `PBOA_OFS_OFF:  hrdata_d = cfg_q[haddr[6:5]].off_mask;
          `PBOA_OFS_BKPT: hrdata_d = cfg_q[haddr[6:5]].bkpt;
          `PBOA_OFS_CTRL: hrdata_d = {31'h00000000, cfg_q[haddr[6:5]].en};
          `PBOA_OFS_POS:  hrdata_d = pos_q[haddr[6:5]];
          default:        hrdata_d = 32'h00000000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Axis counters and breakpoint compare
  // ------------------------------------------------------------
  always_comb
  begin
    on_sum  = 32'h00000000;
    off_sum = 32'h00000000;
    for (int a = 0; a < `PBOA_AXES; a++)
    begin
      pre_wr[a]  = wr && !dph_q.addr[7] && (ax == 2'(a))
                   && (sub == `PBOA_OFS_PRE);
      sft_wr[a]  = wr && !dph_q.addr[7] && (ax == 2'(a))
                   && (sub == `PBOA_OFS_SFT);
      mask_wr[a] = wr && !dph_q.addr[7] && (ax == 2'(a))
                   && ((sub == `PBOA_OFS_ON) || (sub == `PBOA_OFS_OFF));
      step[a]    = {31'h00000000, enc_up[a]} - {31'h00000000, enc_dn[a]};
      cfg_d[a]   = cfg_q[a];
      if (wr && !dph_q.addr[7] && (ax == 2'(a)))
      begin
        case (sub)
          `PBOA_OFS_ON:   cfg_d[a].on_mask  = hwdata;
          `PBOA_OFS_OFF:  cfg_d[a].off_mask = hwdata;
          `PBOA_OFS_BKPT: cfg_d[a].bkpt     = hwdata;
          `PBOA_OFS_CTRL: cfg_d[a].en       = hwdata[0];
          default:        cfg_d[a].en       = cfg_q[a].en;
        endcase
      end
      if (pre_wr[a] || sft_wr[a])
        cfg_d[a].en = 1'b0;
      if (pre_wr[a])
        pos_d[a] = hwdata + step[a];
      else if (sft_wr[a])
        pos_d[a] = pos_q[a] + hwdata + step[a];
      else
        pos_d[a] = pos_q[a] + step[a];
      fire[a] = cfg_q[a].en && !pre_wr[a] && !sft_wr[a]
                && (pos_d[a] == cfg_q[a].bkpt)
                && (pos_q[a] != cfg_q[a].bkpt);
      if (fire[a])
      begin
        on_sum  = on_sum | cfg_q[a].on_mask;
        off_sum = off_sum | cfg_q[a].off_mask;
      end
    end
  end

  // ------------------------------------------------------------
  // Output levels
  // ------------------------------------------------------------
  always_comb
  begin
    gpo_d = gpo_wr ? hwdata : gpo_q;
    gpo_d = (gpo_d & ~on_sum) | off_sum;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_q    <= '0;
      hrdata_q <= 32'h00000000;
    end
    else
    begin
      dph_q    <= dph_d;
      hrdata_q <= hrdata_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fire_q <= '0;
      for (int a = 0; a < `PBOA_AXES; a++)
      begin
        cfg_q[a].on_mask  <= `PBOA_RST_MASK;
        cfg_q[a].off_mask <= `PBOA_RST_MASK;
        cfg_q[a].bkpt     <= `PBOA_RST_BKPT;
        cfg_q[a].en       <= `PBOA_RST_EN;
        pos_q[a]          <= `PBOA_RST_POS;
      end
    end
    else
    begin
      fire_q <= fire;
      for (int a = 0; a < `PBOA_AXES; a++)
      begin
        cfg_q[a] <= cfg_d[a];
        pos_q[a] <= pos_d[a];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      gpo_q <= `PBOA_RST_GPO;
    else
      gpo_q <= gpo_d;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_untouched_hold;
    @(posedge hclk) disable iff (!hresetn)
      (|fire && !gpo_wr) |=>
        (((gpo_q ^ $past(gpo_q)) & ~$past(on_sum | off_sum)) == 0);
  endproperty
  a_untouched_hold: assert property (p_untouched_hold)
    else $error("unmasked output changed on breakpoint");

  property p_quiet_stable;
    @(posedge hclk) disable iff (!hresetn)
      (!(|fire) && !gpo_wr) |=> $stable(gpo_q);
  endproperty
  a_quiet_stable: assert property (p_quiet_stable)
    else $error("outputs changed without event or write");

  property p_event_out;
    @(posedge hclk) disable iff (!hresetn)
      |fire |=> (bkpt_event == $past(fire));
  endproperty
  a_event_out: assert property (p_event_out)
    else $error("event output does not follow breakpoint");

  for (genvar g = 0; g < `PBOA_AXES; g++)
  begin : g_chk
    property p_off_high;
      @(posedge hclk) disable iff (!hresetn)
        fire[g] |=> ((gpo_q & $past(cfg_q[g].off_mask))
                     == $past(cfg_q[g].off_mask));
    endproperty
    a_off_high: assert property (p_off_high)
      else $error("off mask outputs not high");

    property p_on_low;
      @(posedge hclk) disable iff (!hresetn)
        fire[g] |=> ((gpo_q & $past(cfg_q[g].on_mask & ~off_sum)) == 0);
    endproperty
    a_on_low: assert property (p_on_low)
      else $error("on mask outputs not low");

    property p_no_en_no_fire;
      @(posedge hclk) disable iff (!hresetn)
        !cfg_q[g].en |-> !fire[g];
    endproperty
    a_no_en_no_fire: assert property (p_no_en_no_fire)
      else $error("breakpoint fired while disabled");

    property p_mask_keep;
      @(posedge hclk) disable iff (!hresetn)
        !mask_wr[g] |=> ($stable(cfg_q[g].on_mask)
                         && $stable(cfg_q[g].off_mask));
    endproperty
    a_mask_keep: assert property (p_mask_keep)
      else $error("mask changed without write");

    property p_preset;
      @(posedge hclk) disable iff (!hresetn)
        pre_wr[g] |=> (pos_q[g] == $past(hwdata) + $past(step[g]))
                      && !cfg_q[g].en;
    endproperty
    a_preset: assert property (p_preset)
      else $error("preset value or enable wrong");

    property p_pre_dis;
      @(posedge hclk) disable iff (!hresetn)
        pre_wr[g] |=> !cfg_q[g].en;
    endproperty
    a_pre_dis: assert property (p_pre_dis)
      else $error("preset left breakpoint enabled");

    property p_shift;
      @(posedge hclk) disable iff (!hresetn)
        sft_wr[g] |=> (pos_q[g] == $past(pos_q[g]) + $past(hwdata)
                                   + $past(step[g]));
    endproperty
    a_shift: assert property (p_shift)
      else $error("shift lost counts");

    property p_sft_dis;
      @(posedge hclk) disable iff (!hresetn)
        sft_wr[g] |=> !cfg_q[g].en;
    endproperty
    a_sft_dis: assert property (p_sft_dis)
      else $error("shift left breakpoint enabled");

    property p_count;
      @(posedge hclk) disable iff (!hresetn)
        (!pre_wr[g] && !sft_wr[g]) |=>
          (pos_q[g] == $past(pos_q[g]) + $past(step[g]));
    endproperty
    a_count: assert property (p_count)
      else $error("encoder step lost");

    property p_event_dis;
      @(posedge hclk) disable iff (!hresetn)
        !cfg_q[g].en |=> !bkpt_event[g];
    endproperty
    a_event_dis: assert property (p_event_dis)
      else $error("event raised while disabled");

    property p_event_at_bkpt;
      @(posedge hclk) disable iff (!hresetn)
        bkpt_event[g] |-> (pos_q[g] == $past(cfg_q[g].bkpt));
    endproperty
    a_event_at_bkpt: assert property (p_event_at_bkpt)
      else $error("event raised away from breakpoint");

    property p_on_wr;
      @(posedge hclk) disable iff (!hresetn)
        (mask_wr[g] && (sub == `PBOA_OFS_ON)) |=>
          (cfg_q[g].on_mask == $past(hwdata));
    endproperty
    a_on_wr: assert property (p_on_wr)
      else $error("on mask not stored whole");

    property p_off_wr;
      @(posedge hclk) disable iff (!hresetn)
        (mask_wr[g] && (sub == `PBOA_OFS_OFF)) |=>
          (cfg_q[g].off_mask == $past(hwdata));
    endproperty
    a_off_wr: assert property (p_off_wr)
      else $error("off mask not stored whole");

    property p_en_keep;
      @(posedge hclk) disable iff (!hresetn)
        !wr |=> $stable(cfg_q[g].en);
    endproperty
    a_en_keep: assert property (p_en_keep)
      else $error("enable changed without write");
  end

  property p_gpo_write;
    @(posedge hclk) disable iff (!hresetn)
      (gpo_wr && !(|fire)) |=> (gpo_q == $past(hwdata));
  endproperty
  a_gpo_write: assert property (p_gpo_write)
    else $error("output write did not land");

  c_fire: cover property (@(posedge hclk) disable iff (!hresetn)
    |fire);
  c_two_fire: cover property (@(posedge hclk) disable iff (!hresetn)
    $countones(fire) > 1);
  c_shift_step: cover property (@(posedge hclk) disable iff (!hresetn)
    (|sft_wr) && (|enc_up));
  c_preset: cover property (@(posedge hclk) disable iff (!hresetn)
    |pre_wr);

endmodule

// File: pboa_enc_model.sv
// Encoder step source standing in for the axis feedback sensors.
// Assumes steps is called right after a rising hclk edge.
`timescale 1ns/1ps
module pboa_enc_model
(
  input  wire logic       hclk,
  output logic      [3:0] enc_up,
  output logic      [3:0] enc_dn
);
  // ----------------------------------------
  // Step pulses
  // ----------------------------------------
  initial
  begin
    enc_up = 4'h0;
    enc_dn = 4'h0;
  end
  // One pulse per clock, n pulses one way
  task automatic steps(input int ax, input int n, input bit up);
    repeat (n)
    begin
      enc_up <= up ? 4'(1 << ax) : 4'h0;
      enc_dn <= up ? 4'h0 : 4'(1 << ax);
      @(posedge hclk);
    end
    enc_up <= 4'h0;
    enc_dn <= 4'h0;
  endtask
endmodule

// File: tb_position_breakpoint_output_action.sv
// Self-checking bench for the breakpoint output action block.
// Assumes zero-wait AHB-Lite answers and the encoder step model.
`timescale 1ns/1ps
`include "pboa_params.svh"
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("FAIL %s exp %h got %h", nm, e, g); \
    end \
  end
module tb_position_breakpoint_output_action import pboa_pkg::*;
;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam logic [31:0] ON0  = 32'h8000000E;
  localparam logic [31:0] OFF0 = 32'h00000011;
  localparam logic [31:0] G0   = 32'hF0F0F0F0;
  localparam logic [31:0] ON1  = 32'h000000F0;
  localparam logic [31:0] OFF1 = 32'h00000F00;
  logic        hclk        = 1'b0;
  logic        hresetn     = 1'b0;
  logic [31:0] haddr       = 32'h0;
  logic [1:0]  htrans      = 2'h0;
  logic        hwrite      = 1'b0;
  logic [31:0] hwdata      = 32'h0;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [31:0] gpo;
  logic [31:0] rd;
  logic [3:0]  enc_up;
  logic [3:0]  enc_dn;
  logic [3:0]  bkpt_event;
  int          bad_count   = 0;
  int          checks_done = 0;
  int          ev0         = 0;
  int          ev1         = 0;

  always #10 hclk = ~hclk;
  assign hready = hreadyout;

  pboa_core dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .enc_up(enc_up), .enc_dn(enc_dn),
    .general_output(gpo), .bkpt_event(bkpt_event));

  pboa_enc_model enc (.hclk(hclk), .enc_up(enc_up), .enc_dn(enc_dn));

  always @(posedge hclk)
  begin
    if (bkpt_event[0] === 1'b1) ev0++;
    if (bkpt_event[1] === 1'b1) ev1++;
  end

  // ----------------------------------------
  // Bus tasks and verdict
  // ----------------------------------------
  function automatic logic [7:0] ra(input logic [1:0] a,
                                    input logic [4:0] o);
    ra = {1'b0, a, o};
  endfunction

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdc(string nm, input logic [7:0] a,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic results;
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (2000) @(posedge hclk);
    bad_count++;
    results();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("gpo_rst", `PBOA_OFS_GPO, `PBOA_RST_GPO);
    rdc("pos_rst", ra(0, `PBOA_OFS_POS), `PBOA_RST_POS);
    bus(1'b1, `PBOA_OFS_GPO, G0);
    bus(1'b1, ra(0, `PBOA_OFS_ON), ON0);
    bus(1'b1, ra(0, `PBOA_OFS_OFF), OFF0);
    bus(1'b1, ra(0, `PBOA_OFS_BKPT), 32'h5);
    bus(1'b1, ra(0, `PBOA_OFS_CTRL), 32'h1);
    rdc("off0", ra(0, `PBOA_OFS_OFF), OFF0);
    enc.steps(0, 5, 1'b1);
    rdc("gpo_fire", `PBOA_OFS_GPO, (G0 & ~ON0) | OFF0);
    `CHK("ev0", 1, ev0)
    bus(1'b1, `PBOA_OFS_GPO, 32'h0);
    enc.steps(0, 1, 1'b0);
    rdc("pos_back", ra(0, `PBOA_OFS_POS), 32'h4);
    enc.steps(0, 1, 1'b1);
    rdc("gpo_refire", `PBOA_OFS_GPO, OFF0);
    `CHK("ev0_again", 2, ev0)
    bus(1'b1, ra(1, `PBOA_OFS_OFF), 32'hFFFFFFFF);
    bus(1'b1, ra(1, `PBOA_OFS_BKPT), 32'h3);
    enc.steps(1, 3, 1'b1);
    rdc("gpo_disabled", `PBOA_OFS_GPO, OFF0);
    `CHK("ev1", 0, ev1)
    // Axis stands still during the preset
    bus(1'b1, ra(0, `PBOA_OFS_PRE), 32'h80000000);
    rdc("pos_pre", ra(0, `PBOA_OFS_POS), 32'h80000000);
    rdc("en_pre", ra(0, `PBOA_OFS_CTRL), 32'h0);
    bus(1'b1, ra(0, `PBOA_OFS_CTRL), 32'h1);
    fork
      enc.steps(0, 10, 1'b1);
      bus(1'b1, ra(0, `PBOA_OFS_SFT), 32'hFFFFFFFB);
    join
    rdc("pos_sft", ra(0, `PBOA_OFS_POS), 32'h80000005);
    rdc("en_sft", ra(0, `PBOA_OFS_CTRL), 32'h0);
    bus(1'b1, 8'h7C, 32'hA5A5A5A5);
    rdc("unmapped", 8'h7C, 32'h0);
    bus(1'b1, ra(1, `PBOA_OFS_OFF), OFF1);
    bus(1'b1, ra(1, `PBOA_OFS_ON), ON1);
    bus(1'b1, ra(1, `PBOA_OFS_CTRL), 32'h1);
    bus(1'b1, `PBOA_OFS_GPO, G0);
    rdc("on1", ra(1, `PBOA_OFS_ON), ON1);
    rdc("pre_wo", ra(0, `PBOA_OFS_PRE), 32'h0);
    enc.steps(1, 1, 1'b0);
    rdc("pos1_dn", ra(1, `PBOA_OFS_POS), 32'h2);
    enc.steps(1, 1, 1'b1);
    rdc("gpo_ax1", `PBOA_OFS_GPO, (G0 & ~ON1) | OFF1);
    `CHK("gpo_pin", (G0 & ~ON1) | OFF1, gpo)
    `CHK("ev1_en", 1, ev1)
    `CHK("ev0_quiet", 2, ev0)
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    `CHK("gpo_reset", `PBOA_RST_GPO, gpo)
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("on1_reset", ra(1, `PBOA_OFS_ON), `PBOA_RST_MASK);
    results();
  end
endmodule
